// >>> design/patgen_map.vh
// Purpose: offsets, reset values, source codes and pattern codes
// Assumes: byte-wide registers on a plain strobe port
// Notes: definitions only
`ifndef PATGEN_MAP_VH
`define PATGEN_MAP_VH
`define ADDR_W            8
`define OFS_SRC_SEL_A     8'h52
`define OFS_DRV_EN        8'h56
`define OFS_SRC_SEL       8'h57
`define OFS_PWR_CTL       8'h63
`define OFS_PG_CTL        8'h64
`define OFS_PG_CFG        8'h65
`define OFS_FRAME_TIME    8'h6A
`define OFS_CUST_RED      8'h6B
`define OFS_CUST_GREEN    8'h6C
`define OFS_CUST_BLUE     8'h6D
`define OFS_STATUS        8'h6E
`define RST_PG_CTL        8'h10
`define RST_ZERO          8'h00
`define RST_FRAME_TIME    8'h3C
`define SRC_FIRST         2'b01
`define SRC_SECOND        2'b10
`define PAT_RESERVED_LO   4'h0
`define PAT_WHITE         4'h1
`define PAT_BLACK         4'h2
`define PAT_RED           4'h3
`define PAT_GREEN         4'h4
`define PAT_BLUE          4'h5
`define PAT_HRAMP_FIRST   4'h6
`define PAT_VRAMP_FIRST   4'hA
`define PAT_CUSTOM        4'hE
`define PAT_RESERVED_HI   4'hF
`endif

// >>> design/pix_skid_buf.v
// Purpose: two-entry buffer with valid and ready on both sides
// Assumes: single clock, no word lost when the sink stalls
// Notes: in_ready is decoded from the registered fill level
`timescale 1ns/1ps
`default_nettype none
module pix_skid_buf #(
	parameter WIDTH = 27
) (
	input  wire             ref_clk,
	input  wire             nrst,
	input  wire             in_valid,
	output wire             in_ready,
	input  wire [WIDTH-1:0] in_data,
	output wire             out_valid,
	input  wire             out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem_r [0:1];
	reg             wr_ptr_r;
	reg             rd_ptr_r;
	reg [1:0]       count_r;
	wire            push;
	wire            pop;

	// honest full and empty from the fill count
	assign in_ready  = (count_r != 2'd2);
	assign out_valid = (count_r != 2'd0);
	assign out_data  = mem_r[rd_ptr_r];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	// storage and pointers
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			wr_ptr_r <= 1'b0;
			rd_ptr_r <= 1'b0;
			count_r  <= 2'd0;
			mem_r[0] <= {WIDTH{1'b0}};
			mem_r[1] <= {WIDTH{1'b0}};
		end else begin
			if (push) begin
				mem_r[wr_ptr_r] <= in_data;
				wr_ptr_r        <= ~wr_ptr_r;
			end
			if (pop)
				rd_ptr_r <= ~rd_ptr_r;
			if (push & ~pop)
				count_r <= count_r + 2'd1;
			else if (pop & ~push)
				count_r <= count_r - 2'd1;
		end
	end
endmodule // pix_skid_buf
`default_nettype wire

// >>> design/ramp_scaler.v
// Purpose: map a position inside an active span to an 8-bit level
// Assumes: span is nonzero, position below span
// Notes: level = pos*256/span, evenly spread over the span
`timescale 1ns/1ps
`default_nettype none
module ramp_scaler #(
	parameter POS_W = 12
) (
	input  wire [POS_W-1:0] pos,
	input  wire [POS_W-1:0] span,
	output wire [7:0]       level
);
	wire [POS_W+7:0] scaled;
	wire [POS_W+7:0] quot;

	// scale then divide so steps are equal width
	assign scaled = {pos, 8'h00};
	assign quot   = (span == {POS_W{1'b0}}) ? {(POS_W+8){1'b0}} :
	                scaled / {{8{1'b0}}, span};
	assign level  = (quot[POS_W+7:8] != {POS_W{1'b0}}) ? 8'hFF : quot[7:0];
endmodule // ramp_scaler
`default_nettype wire

// >>> design/test_pattern_and_loopthrough_ctl.v
// Purpose: test pattern generator and loop-through controls
// Assumes: pixel stream on ref_clk with de/vs, registers on strobe port
// Notes: video leaves through a two-entry buffer
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "patgen_map.vh"
module test_pattern_and_loopthrough_ctl #(
	parameter POS_W = 12
) (
	input  wire               ref_clk,
	input  wire               nrst,
	input  wire [7:0]         reg_addr,
	input  wire [7:0]         reg_wdata,
	input  wire               reg_wr,
	input  wire               reg_rd,
	output reg  [7:0]         reg_rdata,
	input  wire               first_receive_input,
	input  wire               second_receive_input,
	output wire               loopthrough_output,
	output wire               loopthrough_tx_powerdown,
	input  wire               pix_valid,
	output wire               pix_ready,
	input  wire [23:0]        pix_rgb,
	input  wire               pix_de,
	input  wire               pix_hs,
	input  wire               pix_vs,
	input  wire [POS_W-1:0]   active_width,
	input  wire [POS_W-1:0]   active_height,
	output wire               vid_valid,
	input  wire               vid_ready,
	output wire [23:0]        vid_rgb,
	output wire               vid_de,
	output wire               vid_hs,
	output wire               vid_vs
);
	// one-hot output-source states
	localparam [3:0] ST_PASS = 4'b0001;
	localparam [3:0] ST_FIX  = 4'b0010;
	localparam [3:0] ST_BARS = 4'b0100;
	localparam [3:0] ST_COMP = 4'b1000;

	reg               src_sel_a_r;
	reg               drv_en_r;
	reg  [1:0]        src_sel_r;
	reg               pwdn_r;
	reg  [7:0]        pg_ctl_r;
	reg  [1:0]        pg_cfg_r;
	reg  [7:0]        frame_time_r;
	reg  [7:0]        cust_r_r;
	reg  [7:0]        cust_g_r;
	reg  [7:0]        cust_b_r;
	reg  [1:0]        rx0_sync_r;
	reg  [1:0]        rx1_sync_r;
	reg               loop_r;
	reg  [POS_W-1:0]  hpos_r;
	reg  [POS_W-1:0]  vpos_r;
	reg               de_d_r;
	reg               vs_d_r;
	reg  [7:0]        frame_cnt_r;
	reg  [3:0]        scroll_pat_r;
	reg  [3:0]        state;
	reg  [23:0]       col_nxt;
	reg  [23:0]       pat_rgb;
	wire [3:0]        fixed_pattern_select;
	wire              compliance_pattern_enable;
	wire              color_bar_enable;
	wire              band_order_reverse;
	wire              pattern_generator_enable;
	wire              pattern_invert;
	wire              pattern_auto_scroll;
	wire [3:0]        active_pat;
	wire [7:0]        hlev;
	wire [7:0]        vlev;
	wire [7:0]        lev;
	wire [2:0]        bar_idx;
	wire [1:0]        band_idx;
	wire              frame_start;
	wire              take;

	assign fixed_pattern_select      = pg_ctl_r[7:4];
	assign compliance_pattern_enable = pg_ctl_r[3];
	assign color_bar_enable          = pg_ctl_r[2];
	assign band_order_reverse        = pg_ctl_r[1];
	assign pattern_generator_enable  = pg_ctl_r[0];
	assign pattern_invert            = pg_cfg_r[1];
	assign pattern_auto_scroll       = pg_cfg_r[0];
	assign loopthrough_tx_powerdown  = pwdn_r;
	assign take        = pix_valid & pix_ready;
	assign frame_start = take & pix_vs & ~vs_d_r;

	// register writes
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			src_sel_a_r  <= 1'b0;
			drv_en_r     <= 1'b0;
			src_sel_r    <= 2'b00;
			pwdn_r       <= 1'b0;
			pg_ctl_r     <= `RST_PG_CTL;
			pg_cfg_r     <= 2'b00;
			frame_time_r <= `RST_FRAME_TIME;
			cust_r_r     <= `RST_ZERO;
			cust_g_r     <= `RST_ZERO;
			cust_b_r     <= `RST_ZERO;
		end else if (reg_wr) begin
			if (reg_addr == `OFS_SRC_SEL_A)
				src_sel_a_r <= reg_wdata[7];
			else if (reg_addr == `OFS_DRV_EN)
				drv_en_r <= reg_wdata[3];
			else if (reg_addr == `OFS_SRC_SEL)
				src_sel_r <= reg_wdata[2:1];
			else if (reg_addr == `OFS_PWR_CTL)
				pwdn_r <= reg_wdata[0];
			else if (reg_addr == `OFS_PG_CTL)
				pg_ctl_r <= reg_wdata;
			else if (reg_addr == `OFS_PG_CFG)
				pg_cfg_r <= reg_wdata[1:0];
			else if (reg_addr == `OFS_FRAME_TIME)
				frame_time_r <= reg_wdata;
			else if (reg_addr == `OFS_CUST_RED)
				cust_r_r <= reg_wdata;
			else if (reg_addr == `OFS_CUST_GREEN)
				cust_g_r <= reg_wdata;
			else if (reg_addr == `OFS_CUST_BLUE)
				cust_b_r <= reg_wdata;
		end
	end

	// read data one cycle after the strobe, unmapped reads zero
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			if (reg_addr == `OFS_SRC_SEL_A)
				reg_rdata <= {src_sel_a_r, 7'h00};
			else if (reg_addr == `OFS_DRV_EN)
				reg_rdata <= {4'h0, drv_en_r, 3'h0};
			else if (reg_addr == `OFS_SRC_SEL)
				reg_rdata <= {5'h00, src_sel_r, 1'b0};
			else if (reg_addr == `OFS_PWR_CTL)
				reg_rdata <= {7'h00, pwdn_r};
			else if (reg_addr == `OFS_PG_CTL)
				reg_rdata <= pg_ctl_r;
			else if (reg_addr == `OFS_PG_CFG)
				reg_rdata <= {6'h00, pg_cfg_r};
			else if (reg_addr == `OFS_FRAME_TIME)
				reg_rdata <= frame_time_r;
			else if (reg_addr == `OFS_CUST_RED)
				reg_rdata <= cust_r_r;
			else if (reg_addr == `OFS_CUST_GREEN)
				reg_rdata <= cust_g_r;
			else if (reg_addr == `OFS_CUST_BLUE)
				reg_rdata <= cust_b_r;
			else if (reg_addr == `OFS_STATUS)
				reg_rdata <= {state, scroll_pat_r};
			else
				reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// loop-through path: receive pins pass two flops before selection
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rx0_sync_r <= 2'b00;
			rx1_sync_r <= 2'b00;
			loop_r     <= 1'b0;
		end else begin
			rx0_sync_r <= {rx0_sync_r[0], first_receive_input};
			rx1_sync_r <= {rx1_sync_r[0], second_receive_input};
			if (!drv_en_r || pwdn_r)
				loop_r <= 1'b0;
			else if (src_sel_r == `SRC_FIRST)
				loop_r <= rx0_sync_r[1];
			else if (src_sel_r == `SRC_SECOND)
				loop_r <= rx1_sync_r[1];
			else
				loop_r <= 1'b0;
		end
	end
	assign loopthrough_output = loop_r;

	// pixel position and frame counter for scrolling
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			hpos_r       <= {POS_W{1'b0}};
			vpos_r       <= {POS_W{1'b0}};
			de_d_r       <= 1'b0;
			vs_d_r       <= 1'b0;
			frame_cnt_r  <= 8'h00;
			scroll_pat_r <= `PAT_WHITE;
		end else if (take) begin
			de_d_r <= pix_de;
			vs_d_r <= pix_vs;
			if (pix_vs) begin
				hpos_r <= {POS_W{1'b0}};
				vpos_r <= {POS_W{1'b0}};
			end else if (pix_de) begin
				hpos_r <= hpos_r + {{(POS_W-1){1'b0}}, 1'b1};
			end else if (de_d_r) begin
				hpos_r <= {POS_W{1'b0}};
				vpos_r <= vpos_r + {{(POS_W-1){1'b0}}, 1'b1};
			end
			if (frame_start && pattern_auto_scroll) begin
				if (frame_cnt_r >= frame_time_r) begin
					frame_cnt_r <= 8'h00;
					if (scroll_pat_r >= `PAT_CUSTOM)
						scroll_pat_r <= `PAT_WHITE;
					else
						scroll_pat_r <= scroll_pat_r + 4'h1;
				end else begin
					frame_cnt_r <= frame_cnt_r + 8'h01;
				end
			end
		end
	end

	// source priority: pass while generator off, then compliance, bars, else fixed
	always @* begin
		if (!pattern_generator_enable)
			state = ST_PASS;
		else if (compliance_pattern_enable)
			state = ST_COMP;
		else if (color_bar_enable)
			state = ST_BARS;
		else
			state = ST_FIX;
	end

	assign active_pat = pattern_auto_scroll ? scroll_pat_r : fixed_pattern_select;
	assign lev        = (active_pat < `PAT_VRAMP_FIRST) ? hlev : vlev;
	assign bar_idx    = hpos_r[POS_W-1:POS_W-3] ^ 3'b000;
	assign band_idx   = {vpos_r[POS_W-1], hpos_r[POS_W-1]};

	ramp_scaler #(.POS_W(POS_W)) u_hramp (
		.pos   (hpos_r),
		.span  (active_width),
		.level (hlev)
	);
	ramp_scaler #(.POS_W(POS_W)) u_vramp (
		.pos   (vpos_r),
		.span  (active_height),
		.level (vlev)
	);

	// colour of the selected pattern before inversion
	always @* begin
		col_nxt = 24'h00_0000;
		case (state)
			ST_COMP: begin
				// band pattern, 2x2 quadrants from top left
				case (band_idx)
					2'd0: col_nxt = band_order_reverse ? 24'h00_00FF : 24'hFF_FF00;
					2'd1: col_nxt = 24'h00_FFFF;
					2'd2: col_nxt = band_order_reverse ? 24'hFF_FF00 : 24'h00_00FF;
					default: col_nxt = 24'hFF_0000;
				endcase
			end
			ST_BARS: begin
				case (bar_idx)
					3'd0: col_nxt = 24'hFF_FFFF;
					3'd1: col_nxt = 24'hFF_FF00;
					3'd2: col_nxt = 24'h00_FFFF;
					3'd3: col_nxt = 24'h00_FF00;
					3'd4: col_nxt = 24'hFF_00FF;
					3'd5: col_nxt = 24'hFF_0000;
					3'd6: col_nxt = 24'h00_00FF;
					default: col_nxt = 24'h00_0000;
				endcase
			end
			ST_FIX: begin
				case (active_pat)
					`PAT_WHITE: col_nxt = 24'hFF_FFFF;
					`PAT_BLACK: col_nxt = 24'h00_0000;
					`PAT_RED:   col_nxt = 24'hFF_0000;
					`PAT_GREEN: col_nxt = 24'h00_FF00;
					`PAT_BLUE:  col_nxt = 24'h00_00FF;
					4'h6, 4'hA: col_nxt = {lev, lev, lev};
					4'h7, 4'hB: col_nxt = {lev, 16'h0000};
					4'h8, 4'hC: col_nxt = {8'h00, lev, 8'h00};
					4'h9, 4'hD: col_nxt = {16'h0000, lev};
					`PAT_CUSTOM: col_nxt = {cust_r_r, cust_g_r, cust_b_r};
					default: col_nxt = 24'h00_0000; // reserved codes show black
				endcase
			end
			default: col_nxt = pix_rgb;
		endcase
	end

	// inverted member of each pair; passthrough untouched
	always @* begin
		if (state != ST_PASS && pattern_invert)
			pat_rgb = ~col_nxt;
		else
			pat_rgb = col_nxt;
	end

	pix_skid_buf #(.WIDTH(27)) u_buf (
		.ref_clk   (ref_clk),
		.nrst      (nrst),
		.in_valid  (pix_valid),
		.in_ready  (pix_ready),
		.in_data   ({pat_rgb, pix_de, pix_hs, pix_vs}),
		.out_valid (vid_valid),
		.out_ready (vid_ready),
		.out_data  ({vid_rgb, vid_de, vid_hs, vid_vs})
	);
endmodule // test_pattern_and_loopthrough_ctl
`default_nettype wire

// >>> test/patgen_properties.sv
// Purpose: port-level checks of the pattern and loop-through block
// Assumes: one clock, strobe register port, controls seen only via bus writes
// Notes: shadows the loop-through and generator enables from writes
`timescale 1ns/1ps
`default_nettype none
module patgen_properties (
	input wire logic        ref_clk,
	input wire logic        nrst,
	input wire logic [7:0]  reg_addr,
	input wire logic [7:0]  reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [7:0]  reg_rdata,
	input wire logic        first_receive_input,
	input wire logic        second_receive_input,
	input wire logic        loopthrough_output,
	input wire logic        loopthrough_tx_powerdown,
	input wire logic        pix_valid,
	input wire logic        pix_ready,
	input wire logic [23:0] pix_rgb,
	input wire logic        vid_valid,
	input wire logic        vid_ready,
	input wire logic [23:0] vid_rgb
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	logic       en_r;
	logic       pg_r;
	logic [1:0] sel_r;
	logic [2:0] quiet_r;
	// shadow controls and count quiet cycles since the last write
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			{en_r, pg_r, sel_r, quiet_r} <= '0;
		end else begin
			quiet_r <= reg_wr ? 3'h0 : quiet_r + {2'h0, quiet_r != 3'h7};
			if (reg_wr && reg_addr == 8'h56) en_r <= reg_wdata[3];
			if (reg_wr && reg_addr == 8'h57) sel_r <= reg_wdata[2:1];
			if (reg_wr && reg_addr == 8'h64) pg_r <= reg_wdata[0];
		end
	end
	a_pwdn_level: assert property (reg_wr && reg_addr == 8'h63
		|=> loopthrough_tx_powerdown == $past(reg_wdata[0])) else $error("power-down level wrong");
	a_pwdn_silence: assert property (loopthrough_tx_powerdown
		&& $past(loopthrough_tx_powerdown) |-> !loopthrough_output) else $error("output while down");
	a_loop_first: assert property (quiet_r > 3'h1 && en_r && !loopthrough_tx_powerdown
		&& sel_r == 2'b01 |-> loopthrough_output == $past(first_receive_input, 3))
		else $error("first input not routed");
	a_loop_second: assert property (quiet_r > 3'h1 && en_r && !loopthrough_tx_powerdown
		&& sel_r == 2'b10 |-> loopthrough_output == $past(second_receive_input, 3))
		else $error("second input not routed");
	a_loop_off: assert property (quiet_r > 3'h1 && !(en_r && ^sel_r)
		|-> !loopthrough_output) else $error("output without valid route");
	a_read_reserved: assert property ($past(reg_rd) && $past(reg_addr) == 8'h63
		|-> reg_rdata[7:1] == 7'h00) else $error("reserved bits read nonzero");
	a_word_taken: assert property (pix_valid && pix_ready |=> vid_valid) else $error("word lost");
	a_word_held: assert property (vid_valid && !vid_ready
		|=> vid_valid && $stable(vid_rgb)) else $error("stalled word changed");
	a_full_refuse: assert property (!pix_ready |-> vid_valid) else $error("refused while empty");
	a_pass_through: assert property (!pg_r && quiet_r > 3'h1 && !vid_valid
		&& pix_valid && pix_ready |=> vid_rgb == $past(pix_rgb)) else $error("pixel altered");
endmodule // patgen_properties
bind test_pattern_and_loopthrough_ctl patgen_properties patgen_properties_i (.ref_clk, .nrst,
	.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .first_receive_input,
	.second_receive_input, .loopthrough_output, .loopthrough_tx_powerdown, .pix_valid,
	.pix_ready, .pix_rgb, .vid_valid, .vid_ready, .vid_rgb);
`default_nettype wire

// >>> test/tb_test_pattern_and_loopthrough_ctl.sv
// Purpose: self-checking bench for the pattern and loop-through block
// Assumes: 25 MHz clock, sink model on the video side
// Notes: one task per scenario
`timescale 1ns/1ps
`default_nettype none
module tb_test_pattern_and_loopthrough_ctl;
	logic        ref_clk = 1'b0;
	logic        nrst = 1'b0;
	logic [7:0]  reg_addr = 8'h00;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [7:0]  reg_rdata;
	logic        first_receive_input = 1'b0;
	logic        second_receive_input = 1'b0;
	logic        loopthrough_output;
	logic        loopthrough_tx_powerdown;
	logic        pix_valid = 1'b0;
	logic        pix_ready;
	logic [23:0] pix_rgb = 24'h0;
	logic        pix_de = 1'b0;
	logic        pix_vs = 1'b0;
	logic        blank = 1'b0;
	logic        vid_de;
	logic        vid_hs;
	logic        vid_vs;
	logic        vid_valid;
	logic        vid_ready;
	logic [23:0] vid_rgb;
	logic        stall = 1'b0;
	int          n_errors = 0;
	int          checks_done = 0;
	// free-running pixel clock
	always #20 ref_clk = ~ref_clk;
	test_pattern_and_loopthrough_ctl test_pattern_and_loopthrough_ctl_i (.ref_clk, .nrst,
		.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .first_receive_input,
		.second_receive_input, .loopthrough_output, .loopthrough_tx_powerdown, .pix_valid,
		.pix_ready, .pix_rgb, .pix_de, .pix_hs(1'b0), .pix_vs, .active_width(12'h040),
		.active_height(12'h020), .vid_valid, .vid_ready, .vid_rgb, .vid_de, .vid_hs, .vid_vs);
	vid_sink_model vid_sink_model_i (.ref_clk, .nrst, .stall, .vid_valid, .vid_rgb, .vid_ready);
	task chk(input logic [23:0] got, input logic [23:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		chk({16'h0, reg_rdata}, {16'h0, e});
	endtask
	task px(input logic [23:0] c);
		int k;
		@(posedge ref_clk);
		pix_valid <= 1'b1;
		pix_rgb <= c;
		pix_de <= !blank;
		k = 0;
		@(negedge ref_clk);
		while (!pix_ready && k < 64) begin
			k++;
			@(negedge ref_clk);
		end
		@(posedge ref_clk);
		pix_valid <= 1'b0;
		pix_de <= 1'b0;
	endtask
	task get(output logic [23:0] w);
		int k;
		k = 0;
		#1;
		while (vid_sink_model_i.q.size() == 0 && k < 64) begin
			k++;
			@(posedge ref_clk);
			#1;
		end
		w = (vid_sink_model_i.q.size() > 0) ? vid_sink_model_i.q.pop_front() : 24'hxx_xxxx;
	endtask
	task lt(input logic e);
		repeat (4) @(posedge ref_clk);
		#1;
		chk({23'h0, loopthrough_output}, {23'h0, e});
	endtask
	task t_regs;
		rd(8'h64, 8'h10);
		rd(8'h57, 8'h00);
		rd(8'h63, 8'h00);
		wr(8'h57, 8'hFF);
		rd(8'h57, 8'h06);
		wr(8'h63, 8'hFF);
		rd(8'h63, 8'h01);
		wr(8'h00, 8'hFF);
		rd(8'h00, 8'h00);
	endtask
	task t_loop;
		wr(8'h63, 8'h00);
		wr(8'h56, 8'h08);
		wr(8'h52, 8'h00);
		wr(8'h57, 8'h02);
		first_receive_input <= 1'b1;
		lt(1'b1);
		first_receive_input <= 1'b0;
		second_receive_input <= 1'b1;
		lt(1'b0);
		wr(8'h52, 8'h80);
		wr(8'h57, 8'h04);
		lt(1'b1);
		wr(8'h57, 8'h06);
		lt(1'b0);
		wr(8'h57, 8'h04);
		wr(8'h63, 8'h01);
		lt(1'b0);
		chk({23'h0, loopthrough_tx_powerdown}, 24'h1);
		wr(8'h63, 8'h00);
		lt(1'b1);
		wr(8'h56, 8'h00);
		lt(1'b0);
	endtask
	task t_pass;
		logic [23:0] w;
		wr(8'h64, 8'h10);
		stall <= 1'b1;
		px(24'hA5_0F3C);
		px(24'h5A_F0C3);
		repeat (2) @(posedge ref_clk);
		#1;
		chk({23'h0, pix_ready}, 24'h0);
		chk({21'h0, vid_de, vid_hs, vid_vs}, 24'h4);
		stall <= 1'b0;
		get(w);
		chk(w, 24'hA5_0F3C);
		get(w);
		chk(w, 24'h5A_F0C3);
	endtask
	task t_fixed;
		logic [23:0] w;
		logic [3:0]  codes [6] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'hE};
		logic [23:0] cols [6] = '{24'hFF_FFFF, 24'h0, 24'hFF_0000, 24'h00_FF00, 24'h00_00FF,
			24'h12_3456};
		wr(8'h63, 8'h01);
		wr(8'h6B, 8'h12);
		wr(8'h6C, 8'h34);
		wr(8'h6D, 8'h56);
		for (int i = 0; i < 2; i++) begin
			wr(8'h65, {6'h0, i[0], 1'b0});
			for (int j = 0; j < 6; j++) begin
				wr(8'h64, {codes[j], 4'h1});
				px(24'h77_7777);
				get(w);
				chk(w, i[0] ? ~cols[j] : cols[j]);
			end
		end
	endtask
	task t_mix;
		logic [23:0] w;
		wr(8'h65, 8'h00);
		wr(8'h64, 8'h1D);
		px(24'h77_7777);
		get(w);
		chk(w, 24'hFF_FF00);
		wr(8'h64, 8'h1F);
		px(24'h77_7777);
		get(w);
		chk(w, 24'h00_00FF);
		wr(8'h64, 8'h35);
		px(24'h77_7777);
		get(w);
		chk(w, 24'hFF_FFFF);
		wr(8'h64, 8'h10);
	endtask
	// scrolling, then horizontal and vertical ramps from a fresh frame start
	task t_scroll;
		logic [23:0] w;
		wr(8'h6A, 8'h00);
		wr(8'h65, 8'h01);
		wr(8'h64, 8'h31);
		px(24'h77_7777);
		get(w);
		chk(w, 24'hFF_FFFF);
		pix_vs <= 1'b1;
		px(24'h77_7777);
		get(w);
		chk(w, 24'hFF_FFFF);
		pix_vs <= 1'b0;
		px(24'h77_7777);
		get(w);
		chk(w, 24'h00_0000);
		wr(8'h65, 8'h00);
		wr(8'h64, 8'h61);
		px(24'h77_7777);
		get(w);
		chk(w, 24'h04_0404);
		wr(8'h64, 8'h71);
		px(24'h77_7777);
		get(w);
		chk(w, 24'h08_0000);
		wr(8'h64, 8'hA1);
		blank <= 1'b1;
		px(24'h77_7777);
		get(w);
		chk(w, 24'h00_0000);
		blank <= 1'b0;
		px(24'h77_7777);
		get(w);
		chk(w, 24'h08_0808);
		wr(8'h64, 8'h10);
	endtask
	task final_report;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (3) @(posedge ref_clk);
		nrst <= 1'b1;
		t_regs;
		t_loop;
		t_pass;
		t_fixed;
		t_mix;
		t_scroll;
		final_report;
	end
	// watchdog against a hang
	initial begin
		repeat (20000) @(posedge ref_clk);
		n_errors++;
		final_report;
	end
endmodule // tb_test_pattern_and_loopthrough_ctl
`default_nettype wire

// >>> test/vid_sink_model.sv
// Purpose: display-side sink for the video stream
// Assumes: ready launched just after a clock edge
// Notes: stall holds ready low; words kept in arrival order
`timescale 1ns/1ps
`default_nettype none
module vid_sink_model (
	input  wire logic        ref_clk,
	input  wire logic        nrst,
	input  wire logic        stall,
	input  wire logic        vid_valid,
	input  wire logic [23:0] vid_rgb,
	output var  logic        vid_ready
);
	logic [23:0] q[$];
	// ready follows the stall request one edge later
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) vid_ready <= 1'b0;
		else vid_ready <= !stall;
	end
	// keep every accepted word
	always @(posedge ref_clk) begin
		if (nrst && vid_valid && vid_ready) q.push_back(vid_rgb);
	end
endmodule // vid_sink_model
`default_nettype wire
